// ### dv/charger_setpoint_regs_properties.sv
`timescale 1ns/100ps
// Pin-level checks of the setpoint bank; host traffic is seen only through the clock line.
module setpoint_checker (
  input wire       sys_clk,
  input wire       resetn,
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       watchdog_expiry_event,
  input wire       safety_timer_expiry_event,
  input wire       regulator_overcurrent_event,
  input wire       button_wake_one_expiry,
  input wire       button_wake_two_expiry,
  input wire       button_reset_warning_expiry,
  input wire       event_irq_q,
  input wire [6:0] regulation_voltage_target_q,
  input wire [8:0] fast_charge_units_q,
  input wire [5:0] precharge_units_q,
  input wire       current_step_range_bit_q
);
  wire      ev_any;
  reg [3:0] scl_hi_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Any event input, gathered so an interrupt can be traced back to its cause.
  assign ev_any = watchdog_expiry_event | safety_timer_expiry_event | regulator_overcurrent_event
    | button_wake_one_expiry | button_wake_two_expiry | button_reset_warning_expiry;
  // A write needs a clock fall, so a long high spell proves the host touched nothing.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      scl_hi_q <= 4'h0;
    else if (!scl_in)
      scl_hi_q <= 4'h0;
    else if (scl_hi_q != 4'hF)
      scl_hi_q <= scl_hi_q + 4'h1;
  end
  sequence s_bus_quiet;
    scl_in [*6];
  endsequence
  property p_reset_values;
    $rose(resetn) |-> regulation_voltage_target_q == 7'h3C && fast_charge_units_q == 9'h036
      && precharge_units_q == 6'h07 && !current_step_range_bit_q && !event_irq_q;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("setpoint outputs wrong after reset");
  property p_reg_max;
    regulation_voltage_target_q <= 7'h64;
  endproperty
  a_reg_max: assert property (p_reg_max)
    else $error("regulation target above ceiling");
  property p_fast_step;
    current_step_range_bit_q ? !fast_charge_units_q[0] : !fast_charge_units_q[8];
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("fast charge units not scaled by range");
  property p_pre_step;
    current_step_range_bit_q ? !precharge_units_q[0] : !precharge_units_q[5];
  endproperty
  a_pre_step: assert property (p_pre_step)
    else $error("precharge units not scaled by range");
  property p_quiet_stable;
    s_bus_quiet |=> $stable(regulation_voltage_target_q) && $stable(fast_charge_units_q)
      && $stable(precharge_units_q) && $stable(current_step_range_bit_q);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable)
    else $error("setpoint moved with the host idle");
  property p_irq_hold;
    s_bus_quiet ##0 event_irq_q |=> event_irq_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a flag read");
  property p_irq_cause;
    $rose(event_irq_q) && scl_hi_q > 4'h6 |-> $past(ev_any, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without an event two clocks before");
  property p_oe_timing;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_oe_timing: assert property (p_oe_timing)
    else $error("data drive changed while the bus clock was high");
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("open drain drive value not low");
endmodule

bind charger_setpoint_regs setpoint_checker setpoint_checker_inst (
  .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .watchdog_expiry_event(watchdog_expiry_event),
  .safety_timer_expiry_event(safety_timer_expiry_event),
  .regulator_overcurrent_event(regulator_overcurrent_event),
  .button_wake_one_expiry(button_wake_one_expiry),
  .button_wake_two_expiry(button_wake_two_expiry),
  .button_reset_warning_expiry(button_reset_warning_expiry),
  .event_irq_q(event_irq_q), .regulation_voltage_target_q(regulation_voltage_target_q),
  .fast_charge_units_q(fast_charge_units_q), .precharge_units_q(precharge_units_q),
  .current_step_range_bit_q(current_step_range_bit_q));

// ### dv/serial_host_model.sv
`timescale 1ns/100ps
// Host on the two-wire bus; each clock phase of a bit lasts four system clocks, above the minimum.
module serial_host_model (
  input  wire sys_clk,
  input  wire sda_line,
  output reg  scl,
  output reg  sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Every move lands on the falling edge, clear of the design's sampling edge.
  task half_bit;
    repeat (4) @(negedge sys_clk);
  endtask
  task start_cond;
    begin
      sda = 1'b1;
      half_bit;
      scl = 1'b1;
      half_bit;
      sda = 1'b0;
      half_bit;
      scl = 1'b0;
    end
  endtask
  task stop_cond;
    begin
      sda = 1'b0;
      half_bit;
      scl = 1'b1;
      half_bit;
      sda = 1'b1;
      half_bit;
    end
  endtask
  // Drives one bit, or releases the line to the pull-up, and samples the wire late in high.
  task bit_io(input reg b, output reg r);
    begin
      sda = b;
      half_bit;
      scl = 1'b1;
      half_bit;
      r = sda_line;
      scl = 1'b0;
    end
  endtask
  task xbyte(input [7:0] d, input reg last, output [7:0] q, output reg a);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], q[i]);
      bit_io(last, a);
    end
  endtask
  task wr(input [6:0] dev, input [7:0] ptr, input [7:0] d, output reg ok);
    reg [7:0] x;
    reg       a0, a1, a2;
    begin
      start_cond;
      xbyte({dev, 1'b0}, 1'b1, x, a0);
      xbyte(ptr, 1'b1, x, a1);
      xbyte(d, 1'b1, x, a2);
      stop_cond;
      ok = !a0 && !a1 && !a2;
    end
  endtask
  // Pointer write, repeated start, one byte read and closed with a not-acknowledge.
  task rd(input [6:0] dev, input [7:0] ptr, output [7:0] q, output reg ok);
    reg [7:0] x;
    reg       a0, a1, a2, a3;
    begin
      start_cond;
      xbyte({dev, 1'b0}, 1'b1, x, a0);
      xbyte(ptr, 1'b1, x, a1);
      start_cond;
      xbyte({dev, 1'b1}, 1'b1, x, a2);
      xbyte(8'hFF, 1'b1, q, a3);
      stop_cond;
      ok = !a0 && !a1 && !a2;
    end
  endtask
endmodule

// ### dv/test_charger_setpoint_regs.sv
`timescale 1ns/100ps
module test_charger_setpoint_regs;
  localparam [6:0]  DEV = 7'h2A; // Arbitrary bus address.
  localparam [47:0] POS = {8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
  reg        sys_clk;
  reg        resetn;
  reg        ce;
  reg  [5:0] ev;
  wire       scl;
  wire       host_sda;
  wire       sda_line;
  wire       sda_out;
  wire       sda_oe;
  wire       event_irq_q;
  wire [6:0] reg_target;
  wire [8:0] fast_units;
  wire [5:0] pre_units;
  wire       range_bit;
  reg  [7:0] q;
  reg        ok;
  integer    errors;
  integer    tests_run;
  integer    i;
  // Open drain data line with a pull-up: low whenever either side pulls it.
  assign sda_line = host_sda & (sda_oe ? sda_out : 1'b1);
  charger_setpoint_regs #(.DEV_ADDR(DEV)) charger_setpoint_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .watchdog_expiry_event(ev[5]),
    .safety_timer_expiry_event(ev[4]), .regulator_overcurrent_event(ev[3]),
    .button_wake_one_expiry(ev[2]), .button_wake_two_expiry(ev[1]),
    .button_reset_warning_expiry(ev[0]), .event_irq_q(event_irq_q),
    .regulation_voltage_target_q(reg_target), .fast_charge_units_q(fast_units),
    .precharge_units_q(pre_units), .current_step_range_bit_q(range_bit));
  serial_host_model serial_host_model_inst (
    .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  task check(input [8:0] seen, input [8:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wrr(input [7:0] a, input [7:0] d);
    begin
      serial_host_model_inst.wr(DEV, a, d, ok);
      check(9'(ok), 9'h001);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    begin
      serial_host_model_inst.rd(DEV, a, q, ok);
      check(9'(ok), 9'h001);
      check(9'(q), 9'(exp));
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Bound on the whole run; the host tasks themselves never wait open-ended.
  initial begin
    #500000;
    errors = errors + 1;
    final_report;
  end
  initial begin
    errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    ce = 1'b1;
    ev = 6'h00;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check(9'(reg_target), 9'h03C);
    check(fast_units, 9'h036);
    check(9'(pre_units), 9'h007);
    check(9'(range_bit), 9'h000);
    rdc(8'h0A, 8'h00);
    rdc(8'h12, 8'h3C);
    rdc(8'h13, 8'h36);
    rdc(8'h14, 8'h07);
    $display("reset values done");
    wrr(8'h0A, 8'h88);
    rdc(8'h0A, 8'h88);
    wrr(8'h12, 8'hE4);
    rdc(8'h12, 8'hE4);
    wrr(8'h12, 8'h65);
    rdc(8'h12, 8'h64);
    check(9'(reg_target), 9'h064);
    wrr(8'h12, 8'h7F);
    rdc(8'h12, 8'h64);
    wrr(8'h12, 8'h00);
    check(9'(reg_target), 9'h000);
    wrr(8'h13, 8'hFF);
    check(fast_units, 9'h0FF);
    wrr(8'h14, 8'h9F);
    rdc(8'h14, 8'h9F);
    check(9'(range_bit), 9'h001);
    check(9'(pre_units), 9'h03E);
    check(fast_units, 9'h1FE);
    wrr(8'h14, 8'h65);
    rdc(8'h14, 8'h65);
    check(9'(pre_units), 9'h005);
    // Unmapped place, and a transfer to a foreign address that must leave things alone.
    wrr(8'h20, 8'h55);
    rdc(8'h20, 8'h00);
    serial_host_model_inst.wr(DEV ^ 7'h01, 8'h13, 8'h00, ok);
    check(9'(ok), 9'h000);
    rdc(8'h13, 8'hFF);
    $display("register access done");
    // Each event while masked: flag kept, interrupt held back until the mask clears.
    for (i = 0; i < 6; i = i + 1) begin
      wrr(8'h0A, 8'h88 | POS[i*8 +: 8]);
      ev[i] = 1'b1;
      @(negedge sys_clk);
      ev[i] = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(9'(event_irq_q), 9'h000);
      wrr(8'h0A, 8'h00);
      check(9'(event_irq_q), 9'h001);
      rdc(8'h03, POS[i*8 +: 8]);
      check(9'(event_irq_q), 9'h000);
    end
    // An event inside a clock-enable gap is frozen out; an unmasked one raises the line.
    ce = 1'b0;
    ev[5] = 1'b1;
    repeat (3) @(negedge sys_clk);
    ev[5] = 1'b0;
    ce = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(9'(event_irq_q), 9'h000);
    ev[5] = 1'b1;
    @(negedge sys_clk);
    ev[5] = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(9'(event_irq_q), 9'h001);
    rdc(8'h03, 8'h40);
    check(9'(event_irq_q), 9'h000);
    $display("event masks done");
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check(9'(reg_target), 9'h03C);
    rdc(8'h14, 8'h07);
    $display("second reset done");
    final_report;
  end
endmodule

// ### logic/charger_regs_defs.vh
`ifndef CHARGER_REGS_DEFS_VH
`define CHARGER_REGS_DEFS_VH

// Register offsets on the serial host port.
`define ADDR_EVENT_FLAGS       8'h03
`define ADDR_FAULT_EVENT_MASK  8'h0A
`define ADDR_BATT_REG_VOLTAGE  8'h12
`define ADDR_FAST_CHARGE_CUR   8'h13
`define ADDR_PRECHARGE_CUR     8'h14

// Reset values.
`define RST_FAULT_EVENT_MASK   8'h00
`define RST_BATT_REG_VOLTAGE   8'h3C
`define RST_FAST_CHARGE_CUR    8'h36
`define RST_PRECHARGE_CUR      8'h07
`define RST_EVENT_FLAGS        8'h00

// Event bit positions, shared by the mask and the flag register.
`define BIT_WATCHDOG           6
`define BIT_SAFETY_TIMER       5
`define BIT_REG_OVERCURRENT    4
`define BIT_BUTTON_WAKE_ONE    2
`define BIT_BUTTON_WAKE_TWO    1
`define BIT_BUTTON_RESET_WARN  0
`define EVENT_BIT_MASK         8'h77

// Field positions.
`define BIT_CURRENT_STEP_RANGE 7
`define REG_CODE_MSB           6
`define PRECHARGE_CODE_MSB     4

// Highest regulation code: 3.6 V + 100 x 10 mV = 4.6 V.
`define REG_CODE_MAX           7'h64

// Serial bus device address; the value is arbitrary.
`define HOST_DEV_ADDR          7'h2A

`endif

// ### logic/charger_setpoint_regs.v
// Overview of operation
// - Fault mask bit 6 set to 1 masks the watchdog expiry interrupt.
// - Fault mask bit 5 set to 1 masks the safety timer expiry interrupt.
// - Fault mask bit 4 set to 1 masks the regulator over-current interrupt.
// - Fault mask bit 2 set to 1 masks the first button wake timer interrupt.
// - Fault mask bit 1 set to 1 masks the second button wake timer interrupt.
// - Fault mask bit 0 set to 1 masks the button reset warning interrupt.
// - Fault mask resets to zero; reserved bits 7 and 3 read and write.
// - Regulation code in bits 6..0 sets 3.6 V plus code times 10 mV.
// - Codes above 4.6 V saturate to the 4.6 V setting.
// - Regulation code resets to 0x3C (4.2 V); reserved bit 7 resets 0, writable.
// - Fast-charge current is code times 1.25 mA with range bit 0.
// - Fast-charge current is code times 2.5 mA with range bit 1.
// - Fast-charge code resets to 0x36, 67.5 mA at default range.
// - Pre-charge bit 7 picks 1.25 mA or 2.5 mA steps; resets to 0.
// - Pre-charge code in bits 4..0 scales by the selected step.
// - Pre-charge code resets to 7; reserved bits 6..5 reset 0, writable.
// - Each event sets a sticky flag, cleared when software reads it.
`timescale 1ns/100ps
`include "charger_regs_defs.vh"

module charger_setpoint_regs #(
  parameter [6:0] DEV_ADDR = `HOST_DEV_ADDR
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       watchdog_expiry_event,
  input  wire       safety_timer_expiry_event,
  input  wire       regulator_overcurrent_event,
  input  wire       button_wake_one_expiry,
  input  wire       button_wake_two_expiry,
  input  wire       button_reset_warning_expiry,
  output reg        event_irq_q,
  output reg  [6:0] regulation_voltage_target_q,
  output reg  [8:0] fast_charge_units_q,
  output reg  [5:0] precharge_units_q,
  output reg        current_step_range_bit_q
);

  // Register storage.
  reg  [7:0] fault_event_mask_q;
  reg  [7:0] battery_regulation_voltage_q;
  reg  [7:0] fast_charge_current_q;
  reg  [7:0] precharge_current_and_range_q;

  // Host port signals.
  wire [7:0] reg_addr;
  wire       wr_strobe;
  wire [7:0] wr_data;
  wire       rd_strobe;
  reg  [7:0] rd_data;

  // Event collection.
  wire [7:0] event_vec;
  wire [7:0] flags;
  wire       flag_clear;

  // Named mask bits, used by the interrupt gate below.
  wire       watchdog_event_mask_bit;
  wire       safety_timer_event_mask_bit;
  wire       regulator_overcurrent_mask_bit;
  wire       button_wake_one_mask_bit;
  wire       button_wake_two_mask_bit;
  wire       button_reset_warning_mask_bit;
  wire [7:0] mask_vec;

  // Field views of the setpoint registers.
  wire [6:0] regulation_code;
  wire [7:0] fast_charge_code;
  wire [4:0] precharge_code;
  wire       current_step_range_bit;
  wire [6:0] write_reg_code;

  serial_host_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_host_port (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .ce          (ce),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe_q    (sda_oe),
    .reg_addr_q  (reg_addr),
    .wr_strobe_q (wr_strobe),
    .wr_data_q   (wr_data),
    .rd_strobe   (rd_strobe),
    .rd_data     (rd_data)
  );

  // Events land at the same bit positions as their mask bits.
  assign event_vec[`BIT_WATCHDOG]          = watchdog_expiry_event;
  assign event_vec[`BIT_SAFETY_TIMER]      = safety_timer_expiry_event;
  assign event_vec[`BIT_REG_OVERCURRENT]   = regulator_overcurrent_event;
  assign event_vec[`BIT_BUTTON_WAKE_ONE]   = button_wake_one_expiry;
  assign event_vec[`BIT_BUTTON_WAKE_TWO]   = button_wake_two_expiry;
  assign event_vec[`BIT_BUTTON_RESET_WARN] = button_reset_warning_expiry;
  assign event_vec[7]                      = 1'b0;
  assign event_vec[3]                      = 1'b0;

  // Flags clear on the byte fetch of a read, not on the pointer write.
  assign flag_clear = rd_strobe & (reg_addr == `ADDR_EVENT_FLAGS);

  event_flag_bank #(
    .WIDTH (8)
  ) u_flags (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .ce       (ce),
    .event_in (event_vec),
    .clear    (flag_clear),
    .flags_q  (flags)
  );

  // Mask bit picks.
  assign watchdog_event_mask_bit        = fault_event_mask_q[`BIT_WATCHDOG];
  assign safety_timer_event_mask_bit    = fault_event_mask_q[`BIT_SAFETY_TIMER];
  assign regulator_overcurrent_mask_bit = fault_event_mask_q[`BIT_REG_OVERCURRENT];
  assign button_wake_one_mask_bit       = fault_event_mask_q[`BIT_BUTTON_WAKE_ONE];
  assign button_wake_two_mask_bit       = fault_event_mask_q[`BIT_BUTTON_WAKE_TWO];
  assign button_reset_warning_mask_bit  = fault_event_mask_q[`BIT_BUTTON_RESET_WARN];

  // Reserved mask bits 7 and 3 store values but gate no event.
  assign mask_vec[`BIT_WATCHDOG]          = watchdog_event_mask_bit;
  assign mask_vec[`BIT_SAFETY_TIMER]      = safety_timer_event_mask_bit;
  assign mask_vec[`BIT_REG_OVERCURRENT]   = regulator_overcurrent_mask_bit;
  assign mask_vec[`BIT_BUTTON_WAKE_ONE]   = button_wake_one_mask_bit;
  assign mask_vec[`BIT_BUTTON_WAKE_TWO]   = button_wake_two_mask_bit;
  assign mask_vec[`BIT_BUTTON_RESET_WARN] = button_reset_warning_mask_bit;
  assign mask_vec[7]                      = 1'b1;
  assign mask_vec[3]                      = 1'b1;

  // Field views.
  assign regulation_code        = battery_regulation_voltage_q[`REG_CODE_MSB:0];
  assign fast_charge_code       = fast_charge_current_q;
  assign precharge_code         = precharge_current_and_range_q[`PRECHARGE_CODE_MSB:0];
  assign current_step_range_bit = precharge_current_and_range_q[`BIT_CURRENT_STEP_RANGE];

  // Saturation is applied at write time so readback shows the code in force.
  assign write_reg_code = (wr_data[6:0] > `REG_CODE_MAX) ? `REG_CODE_MAX : wr_data[6:0];

  // Register writes; every bit, reserved ones included, is writable.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault_event_mask_q            <= `RST_FAULT_EVENT_MASK;
      battery_regulation_voltage_q  <= `RST_BATT_REG_VOLTAGE;
      fast_charge_current_q         <= `RST_FAST_CHARGE_CUR;
      precharge_current_and_range_q <= `RST_PRECHARGE_CUR;
    end else if (ce && wr_strobe) begin
      case (reg_addr)
        `ADDR_FAULT_EVENT_MASK: begin
          fault_event_mask_q <= wr_data;
        end
        `ADDR_BATT_REG_VOLTAGE: begin
          battery_regulation_voltage_q <= {wr_data[7], write_reg_code};
        end
        `ADDR_FAST_CHARGE_CUR: begin
          fast_charge_current_q <= wr_data;
        end
        `ADDR_PRECHARGE_CUR: begin
          precharge_current_and_range_q <= wr_data;
        end
        default: begin
          fast_charge_current_q <= fast_charge_current_q;
        end
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    case (reg_addr)
      `ADDR_EVENT_FLAGS:      rd_data = flags & `EVENT_BIT_MASK;
      `ADDR_FAULT_EVENT_MASK: rd_data = fault_event_mask_q;
      `ADDR_BATT_REG_VOLTAGE: rd_data = battery_regulation_voltage_q;
      `ADDR_FAST_CHARGE_CUR:  rd_data = fast_charge_current_q;
      `ADDR_PRECHARGE_CUR:    rd_data = precharge_current_and_range_q;
      default:                rd_data = 8'h00;
    endcase
  end

  // Analog setpoints in step units: regulation in 10 mV above 3.6 V,
  // currents in 1.25 mA units, doubled when the range bit selects 2.5 mA.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regulation_voltage_target_q <= 7'h3C;
      fast_charge_units_q         <= 9'h036;
      precharge_units_q           <= 6'h07;
      current_step_range_bit_q    <= 1'b0;
      event_irq_q                 <= 1'b0;
    end else if (ce) begin
      regulation_voltage_target_q <= regulation_code;
      current_step_range_bit_q    <= current_step_range_bit;
      if (current_step_range_bit) begin
        fast_charge_units_q <= {fast_charge_code, 1'b0};
        precharge_units_q   <= {precharge_code, 1'b0};
      end else begin
        fast_charge_units_q <= {1'b0, fast_charge_code};
        precharge_units_q   <= {1'b0, precharge_code};
      end
      // A masked flag waits; clearing its mask raises the line if still set.
      event_irq_q <= |(flags & ~mask_vec);
    end
  end

endmodule

// ### logic/event_flag_bank.v
`timescale 1ns/100ps
`include "charger_regs_defs.vh"

// Sticky event flags, cleared as a group when software reads them.
module event_flag_bank #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             resetn,
  input  wire             ce,
  input  wire [WIDTH-1:0] event_in,
  input  wire             clear,
  output reg  [WIDTH-1:0] flags_q
);

  // A new event in the clearing cycle survives, so no event is lost.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      flags_q <= (clear ? {WIDTH{1'b0}} : flags_q) | event_in;
    end
  end

endmodule

// ### logic/serial_host_port.v
`timescale 1ns/100ps
`include "charger_regs_defs.vh"

// Two-wire serial target: pointer write, data write and read, auto increment.
module serial_host_port #(
  parameter [6:0] DEV_ADDR = `HOST_DEV_ADDR
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       ce,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe_q,
  output reg  [7:0] reg_addr_q,
  output reg        wr_strobe_q,
  output reg  [7:0] wr_data_q,
  output wire       rd_strobe,
  input  wire [7:0] rd_data
);

  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_ACK_A = 7'h04;
  localparam [6:0] ST_WRITE = 7'h08;
  localparam [6:0] ST_ACK_W = 7'h10;
  localparam [6:0] ST_READ  = 7'h20;
  localparam [6:0] ST_ACK_R = 7'h40;

  reg  [6:0] state_q;
  reg        scl_q;
  reg        sda_q;
  reg  [2:0] bit_cnt_q;
  reg        byte_done_q;
  reg  [7:0] shift_q;
  reg        read_dir_q;
  reg        ptr_phase_q;
  reg        nack_q;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_seen;
  wire       stop_seen;

  // The line is open drain, so the only level ever driven is low.
  assign sda_out    = 1'b0;
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

  // A byte is fetched when a read begins and after each acknowledged read byte.
  assign rd_strobe = ce & scl_fall & ~start_seen & ~stop_seen &
                     ((state_q == ST_ACK_A && read_dir_q) ||
                      (state_q == ST_ACK_R && !nack_q));

  // Bus sequencer.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= ST_IDLE;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      bit_cnt_q   <= 3'h0;
      byte_done_q <= 1'b0;
      shift_q     <= 8'h00;
      read_dir_q  <= 1'b0;
      ptr_phase_q <= 1'b0;
      nack_q      <= 1'b0;
      sda_oe_q    <= 1'b0;
      reg_addr_q  <= 8'h00;
      wr_strobe_q <= 1'b0;
      wr_data_q   <= 8'h00;
    end else if (ce) begin
      scl_q       <= scl_in;
      sda_q       <= sda_in;
      wr_strobe_q <= 1'b0;
      // The pointer steps while the strobe stands, so the store still sees the byte's own offset.
      if (wr_strobe_q) begin
        reg_addr_q <= reg_addr_q + 8'h01;
      end
      if (start_seen) begin
        state_q     <= ST_ADDR;
        bit_cnt_q   <= 3'h0;
        byte_done_q <= 1'b0;
        sda_oe_q    <= 1'b0;
      end else if (stop_seen) begin
        state_q  <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q     <= {shift_q[6:0], sda_in};
              bit_cnt_q   <= bit_cnt_q + 3'h1;
              byte_done_q <= (bit_cnt_q == 3'h7);
            end else if (scl_fall && byte_done_q) begin
              byte_done_q <= 1'b0;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == DEV_ADDR) begin
                  read_dir_q  <= shift_q[0];
                  ptr_phase_q <= ~shift_q[0];
                  sda_oe_q    <= 1'b1;
                  state_q     <= ST_ACK_A;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                if (ptr_phase_q) begin
                  reg_addr_q  <= shift_q;
                  ptr_phase_q <= 1'b0;
                end else begin
                  wr_strobe_q <= 1'b1;
                  wr_data_q   <= shift_q;
                end
                sda_oe_q <= 1'b1;
                state_q  <= ST_ACK_W;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_WRITE;
            end
          end
          ST_ACK_A, ST_ACK_R: begin
            if (scl_rise) begin
              nack_q <= (state_q == ST_ACK_R) & sda_in;
            end else if (scl_fall) begin
              if (rd_strobe) begin
                shift_q    <= rd_data;
                sda_oe_q   <= ~rd_data[7];
                reg_addr_q <= reg_addr_q + 8'h01;
                bit_cnt_q  <= 3'h0;
                state_q    <= ST_READ;
              end else if (state_q == ST_ACK_A) begin
                sda_oe_q  <= 1'b0;
                bit_cnt_q <= 3'h0;
                state_q   <= ST_WRITE;
              end else begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_IDLE;
              end
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_cnt_q   <= bit_cnt_q + 3'h1;
              byte_done_q <= (bit_cnt_q == 3'h7);
            end else if (scl_fall) begin
              if (byte_done_q) begin
                byte_done_q <= 1'b0;
                sda_oe_q    <= 1'b0;
                state_q     <= ST_ACK_R;
              end else begin
                shift_q  <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];
              end
            end
          end
          default: begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
